/* File: frame_jobs_consts.svh */
// offsets, field positions, reset values and codes of the frame transfer jobs
`ifndef FRAME_JOBS_CONSTS_SVH
`define FRAME_JOBS_CONSTS_SVH

`define ADDR_CTRL        8'h00
`define ADDR_MOD_BASE    8'h04
`define ADDR_SEND_BLOCK  8'h08
`define ADDR_SEND_OFFSET 8'h0c
`define ADDR_SEND_LEN    8'h10
`define ADDR_SEND_CALL   8'h14
`define ADDR_SEND_RESULT 8'h18
`define ADDR_FAULT_INFO  8'h1c
`define ADDR_RECV_BLOCK  8'h20
`define ADDR_RECV_OFFSET 8'h24
`define ADDR_RECV_CALL   8'h28
`define ADDR_RECV_RESULT 8'h2c
`define ADDR_RECV_LEN    8'h30

`define BIT_TRIGGER      0
`define BIT_CANCEL       1
`define BIT_RECV_ENABLE  0
`define BIT_DONE         0
`define BIT_ERROR        1
`define BIT_RESULT       2
`define BIT_BUSY         3
`define STATUS_LSB       16

`define RST_WORD         16'h0000
`define ST_OK            16'h0000
`define ST_SEND_ABORT    16'h0001
`define ST_MODULE_FAULT  16'h1e0f
`define ST_RECV_RESET    16'h0002
`define ST_RECV_DISABLED 16'h0003
`define ST_RECV_OVERLONG 16'h0004

`define MAX_FRAME_BYTES  400
`define CALL_BUDGET      64

`endif

/* File: frame_jobs_pkg.sv */
// types shared by the frame transfer jobs
package frame_jobs_pkg;
  typedef logic [15:0] word_t;
  typedef logic [7:0]  byte_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_READ = 4'b0010,
    S_WAIT = 4'b0100,
    S_PUSH = 4'b1000
  } send_state_t;

  typedef enum logic [1:0] {
    R_IDLE = 2'b01,
    R_MOVE = 2'b10
  } recv_state_t;
endpackage : frame_jobs_pkg

/* File: recv_call_if.sv */
// call and result signals between the controller and the receive job
`timescale 1ns/100ps
`default_nettype none
interface recv_call_if;
  import frame_jobs_pkg::*;
  logic  go;
  logic  enable;
  logic  cancel;
  word_t block;
  word_t offset;
  logic  busy;
  logic  newData;
  logic  error;
  logic  resultBit;
  word_t status;
  word_t length;

  modport ctrl (output go, enable, cancel, block, offset,
                input busy, newData, error, resultBit, status, length);
  modport job  (input go, enable, cancel, block, offset,
                output busy, newData, error, resultBit, status, length);
endinterface : recv_call_if
`default_nettype wire

/* File: frame_receive_job.sv */
// receive job: fetches module frames into memory, call by call
`timescale 1ns/100ps
`default_nettype none
`include "frame_jobs_consts.svh"
module frame_receive_job #(
  parameter int CALL_BUDGET = `CALL_BUDGET,
  parameter int MAX_BYTES   = `MAX_FRAME_BYTES
) (
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  recv_call_if.job                   call,
  input  wire logic                  rxFrameReady,
  input  wire frame_jobs_pkg::byte_t rxByte,
  input  wire logic                  rxValid,
  input  wire logic                  rxLast,
  output var  logic                  rxReady,
  output var  logic                  memWrEn,
  output var  frame_jobs_pkg::word_t memWrAddr,
  output var  frame_jobs_pkg::byte_t memWrData
);
  import frame_jobs_pkg::*;

  recv_state_t state, next_state;
  word_t       count, next_count;
  logic [7:0]  budget, next_budget;
  logic        busy, next_busy, next_rxReady, next_memWrEn;
  logic        newData, next_newData, error, next_error;
  logic        resultBit, next_resultBit;
  word_t       status, next_status, length, next_length;
  word_t       next_memWrAddr;
  byte_t       next_memWrData;

  always_comb begin
    next_state     = state;
    next_count     = count;
    next_budget    = budget;
    next_busy      = busy;
    next_rxReady   = rxReady;
    next_memWrEn   = 1'b0;
    next_memWrAddr = memWrAddr;
    next_memWrData = memWrData;
    next_newData   = newData;
    next_error     = error;
    next_resultBit = resultBit;
    next_status    = status;
    next_length    = length;
    if (call.go) begin
      next_newData = 1'b0;
      next_error   = 1'b0;
      next_status  = `ST_OK;
      next_length  = `RST_WORD;
      next_budget  = 8'(CALL_BUDGET);
      next_busy    = 1'b0;
      next_rxReady = 1'b0;
      if (call.cancel) begin
        next_state = R_IDLE;
        if (state == R_MOVE) begin
          next_error     = 1'b1;
          next_status    = `ST_RECV_RESET;
          next_resultBit = 1'b0;
        end
      end else if (!call.enable) begin
        next_state = R_IDLE;
        if (state == R_MOVE) begin
          next_error     = 1'b1;
          next_status    = `ST_RECV_DISABLED;
          next_resultBit = 1'b0;
        end
      end else if (state == R_MOVE || rxFrameReady) begin
        if (state == R_IDLE)
          next_count = `RST_WORD;
        next_state   = R_MOVE;
        next_busy    = 1'b1;
        next_rxReady = 1'b1;
      end
    end else if (busy) begin
      next_budget = budget - 8'd1;
      if (rxValid && rxReady) begin
        next_memWrEn   = 1'b1;
        next_memWrAddr = 16'(call.offset + count);
        next_memWrData = rxByte;
        next_count     = count + 16'd1;
        if (rxLast) begin
          next_newData   = 1'b1;
          next_length    = count + 16'd1;
          next_resultBit = 1'b1;
          next_state     = R_IDLE;
          next_busy      = 1'b0;
          next_rxReady   = 1'b0;
        end else if (count + 16'd1 >= 16'(MAX_BYTES)) begin
          next_error     = 1'b1;
          next_status    = `ST_RECV_OVERLONG;
          next_resultBit = 1'b0;
          next_state     = R_IDLE;
          next_busy      = 1'b0;
          next_rxReady   = 1'b0;
        end
      end
      if (budget == 8'd1 && next_busy) begin
        next_busy    = 1'b0;
        next_rxReady = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state     <= R_IDLE;
      count     <= `RST_WORD;
      budget    <= 8'h00;
      busy      <= 1'b0;
      rxReady   <= 1'b0;
      memWrEn   <= 1'b0;
      memWrAddr <= `RST_WORD;
      memWrData <= 8'h00;
      newData   <= 1'b0;
      error     <= 1'b0;
      resultBit <= 1'b0;
      status    <= `RST_WORD;
      length    <= `RST_WORD;
    end else begin
      state     <= next_state;
      count     <= next_count;
      budget    <= next_budget;
      busy      <= next_busy;
      rxReady   <= next_rxReady;
      memWrEn   <= next_memWrEn;
      memWrAddr <= next_memWrAddr;
      memWrData <= next_memWrData;
      newData   <= next_newData;
      error     <= next_error;
      resultBit <= next_resultBit;
      status    <= next_status;
      length    <= next_length;
    end
  end

  assign call.busy      = busy;
  assign call.newData   = newData;
  assign call.error     = error;
  assign call.resultBit = resultBit;
  assign call.status    = status;
  assign call.length    = length;
endmodule : frame_receive_job
`default_nettype wire

/* File: frame_transfer_jobs.sv */
// send job, register file and apb slave of the frame transfer jobs
`timescale 1ns/100ps
`default_nettype none
`include "frame_jobs_consts.svh"
module frame_transfer_jobs #(
  parameter int CALL_BUDGET = `CALL_BUDGET,
  parameter int MAX_BYTES   = `MAX_FRAME_BYTES
) (
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  output var  frame_jobs_pkg::word_t moduleBaseAddress,
  output var  logic                  memRdEn,
  output var  frame_jobs_pkg::word_t memRdBlock,
  output var  frame_jobs_pkg::word_t memRdAddr,
  input  wire frame_jobs_pkg::byte_t memRdData,
  output var  frame_jobs_pkg::byte_t txByte,
  output var  logic                  txValid,
  input  wire logic                  txReady,
  input  wire logic                  txFault,
  input  wire frame_jobs_pkg::word_t txFaultCode,
  input  wire logic                  rxFrameReady,
  input  wire frame_jobs_pkg::byte_t rxByte,
  input  wire logic                  rxValid,
  input  wire logic                  rxLast,
  output var  logic                  rxReady,
  output var  logic                  memWrEn,
  output var  frame_jobs_pkg::word_t memWrBlock,
  output var  frame_jobs_pkg::word_t memWrAddr,
  output var  frame_jobs_pkg::byte_t memWrData
);
  import frame_jobs_pkg::*;

  recv_call_if recvCall ();

  // register file
  logic  recvEnable, next_recvEnable;
  word_t next_moduleBaseAddress;
  word_t sendBlock, next_sendBlock;
  word_t sendOffset, next_sendOffset;
  word_t sendLen, next_sendLen;
  word_t recvBlock, next_recvBlock;
  word_t recvOffset, next_recvOffset;
  logic  callActive, next_callActive;
  logic [31:0] next_prdata;
  logic  next_pready, next_pslverr;

  // send job
  send_state_t sendState, next_sendState;
  word_t       count, next_count;
  logic [7:0]  budget, next_budget;
  logic        sendBusy, next_sendBusy;
  logic        prevTrigger, next_prevTrigger;
  logic        done, next_done, error, next_error;
  logic        resultBit, next_resultBit;
  word_t       status, next_status;
  word_t       faultDetail, next_faultDetail;
  logic        next_memRdEn, next_txValid;
  word_t       next_memRdAddr;
  byte_t       next_txByte;

  logic access, commit, sendGo, recvGo, mapped;
  logic trigger, cancel;

  assign access  = psel && penable && !pready;
  assign commit  = psel && penable && pready && pwrite;
  assign sendGo  = access && pwrite && !callActive && paddr == `ADDR_SEND_CALL;
  assign recvGo  = access && pwrite && !callActive && paddr == `ADDR_RECV_CALL;
  assign trigger = pwdata[`BIT_TRIGGER];
  assign cancel  = pwdata[`BIT_CANCEL];

  assign recvCall.go     = recvGo;
  assign recvCall.enable = recvEnable;
  assign recvCall.cancel = pwdata[`BIT_CANCEL];
  assign recvCall.block  = recvBlock;
  assign recvCall.offset = recvOffset;
  assign memRdBlock      = sendBlock;
  assign memWrBlock      = recvBlock;

  always_comb begin
    unique case (paddr)
      `ADDR_CTRL, `ADDR_MOD_BASE, `ADDR_SEND_BLOCK, `ADDR_SEND_OFFSET,
      `ADDR_SEND_LEN, `ADDR_SEND_CALL, `ADDR_SEND_RESULT, `ADDR_FAULT_INFO,
      `ADDR_RECV_BLOCK, `ADDR_RECV_OFFSET, `ADDR_RECV_CALL,
      `ADDR_RECV_RESULT, `ADDR_RECV_LEN: mapped = 1'b1;
      default:                           mapped = 1'b0;
    endcase
  end

  // apb slave and register file
  always_comb begin
    next_recvEnable        = recvEnable;
    next_moduleBaseAddress = moduleBaseAddress;
    next_sendBlock         = sendBlock;
    next_sendOffset        = sendOffset;
    next_sendLen           = sendLen;
    next_recvBlock         = recvBlock;
    next_recvOffset        = recvOffset;
    next_callActive        = callActive;
    next_prdata            = prdata;
    next_pready            = 1'b0;
    next_pslverr           = 1'b0;
    if (access) begin
      if (pwrite && (paddr == `ADDR_SEND_CALL || paddr == `ADDR_RECV_CALL)) begin
        if (!callActive) begin
          next_callActive = 1'b1;
        end else if (!sendBusy && !recvCall.busy) begin
          next_callActive = 1'b0;
          next_pready     = 1'b1;
        end
      end else begin
        next_pready  = 1'b1;
        next_pslverr = !mapped;
        next_prdata  = 32'h0000_0000;
        if (!pwrite) begin
          unique case (paddr)
            `ADDR_CTRL:        next_prdata[`BIT_RECV_ENABLE] = recvEnable;
            `ADDR_MOD_BASE:    next_prdata[15:0] = moduleBaseAddress;
            `ADDR_SEND_BLOCK:  next_prdata[15:0] = sendBlock;
            `ADDR_SEND_OFFSET: next_prdata[15:0] = sendOffset;
            `ADDR_SEND_LEN:    next_prdata[15:0] = sendLen;
            `ADDR_SEND_RESULT: begin
              next_prdata[`BIT_DONE]   = done;
              next_prdata[`BIT_ERROR]  = error;
              next_prdata[`BIT_RESULT] = resultBit;
              next_prdata[`BIT_BUSY]   = sendState != S_IDLE;
              next_prdata[31:16]       = status;
            end
            `ADDR_FAULT_INFO:  next_prdata[15:0] = faultDetail;
            `ADDR_RECV_BLOCK:  next_prdata[15:0] = recvBlock;
            `ADDR_RECV_OFFSET: next_prdata[15:0] = recvOffset;
            `ADDR_RECV_RESULT: begin
              next_prdata[`BIT_DONE]   = recvCall.newData;
              next_prdata[`BIT_ERROR]  = recvCall.error;
              next_prdata[`BIT_RESULT] = recvCall.resultBit;
              next_prdata[31:16]       = recvCall.status;
            end
            `ADDR_RECV_LEN:    next_prdata[15:0] = recvCall.length;
            default:           next_prdata = 32'h0000_0000;
          endcase
        end
      end
    end
    if (commit) begin
      unique case (paddr)
        `ADDR_CTRL:        next_recvEnable = pwdata[`BIT_RECV_ENABLE];
        `ADDR_MOD_BASE:    next_moduleBaseAddress = pwdata[15:0];
        `ADDR_SEND_BLOCK:  next_sendBlock = pwdata[15:0];
        `ADDR_SEND_OFFSET: next_sendOffset = pwdata[15:0];
        `ADDR_SEND_LEN:    next_sendLen = pwdata[15:0];
        `ADDR_RECV_BLOCK:  next_recvBlock = pwdata[15:0];
        `ADDR_RECV_OFFSET: next_recvOffset = pwdata[15:0];
        default:           next_recvEnable = recvEnable;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      recvEnable        <= 1'b0;
      moduleBaseAddress <= `RST_WORD;
      sendBlock         <= `RST_WORD;
      sendOffset        <= `RST_WORD;
      sendLen           <= `RST_WORD;
      recvBlock         <= `RST_WORD;
      recvOffset        <= `RST_WORD;
      callActive        <= 1'b0;
      prdata            <= 32'h0000_0000;
      pready            <= 1'b0;
      pslverr           <= 1'b0;
    end else begin
      recvEnable        <= next_recvEnable;
      moduleBaseAddress <= next_moduleBaseAddress;
      sendBlock         <= next_sendBlock;
      sendOffset        <= next_sendOffset;
      sendLen           <= next_sendLen;
      recvBlock         <= next_recvBlock;
      recvOffset        <= next_recvOffset;
      callActive        <= next_callActive;
      prdata            <= next_prdata;
      pready            <= next_pready;
      pslverr           <= next_pslverr;
    end
  end

  // send job: one call advances the copy by up to CALL_BUDGET cycles
  always_comb begin
    next_sendState   = sendState;
    next_count       = count;
    next_budget      = budget;
    next_sendBusy    = sendBusy;
    next_prevTrigger = prevTrigger;
    next_done        = done;
    next_error       = error;
    next_resultBit   = resultBit;
    next_status      = status;
    next_faultDetail = faultDetail;
    next_memRdEn     = 1'b0;
    next_memRdAddr   = memRdAddr;
    next_txByte      = txByte;
    next_txValid     = txValid;
    if (sendGo) begin
      next_done        = 1'b0;
      next_error       = 1'b0;
      next_status      = `ST_OK;
      next_prevTrigger = trigger;
      next_budget      = 8'(CALL_BUDGET);
      next_sendBusy    = 1'b0;
      if (cancel) begin
        next_sendState = S_IDLE;
        if (sendState != S_IDLE) begin
          next_error     = 1'b1;
          next_status    = `ST_SEND_ABORT;
          next_resultBit = 1'b0;
        end
      end else if (sendState != S_IDLE) begin
        next_sendBusy = 1'b1;
      end else if (trigger && !prevTrigger) begin
        next_count     = `RST_WORD;
        next_sendState = S_READ;
        next_sendBusy  = 1'b1;
      end
    end else if (sendBusy) begin
      next_budget = budget - 8'd1;
      unique case (sendState)
        S_READ: begin
          next_memRdEn   = 1'b1;
          next_memRdAddr = 16'(sendOffset + count);
          next_sendState = S_WAIT;
        end
        S_WAIT: begin
          next_txByte    = memRdData;
          next_txValid   = 1'b1;
          next_sendState = S_PUSH;
        end
        S_PUSH: begin
          if (txReady) begin
            next_txValid = 1'b0;
            next_count   = count + 16'd1;
            if (count + 16'd1 >= sendLen) begin
              next_done      = 1'b1;
              next_status    = `ST_OK;
              next_resultBit = 1'b1;
              next_sendState = S_IDLE;
              next_sendBusy  = 1'b0;
            end else begin
              next_sendState = S_READ;
            end
          end
        end
        S_IDLE: next_sendBusy = 1'b0;
      endcase
      if (txFault) begin
        next_error       = 1'b1;
        next_status      = `ST_MODULE_FAULT;
        next_faultDetail = txFaultCode;
        next_resultBit   = 1'b0;
        next_txValid     = 1'b0;
        next_sendState   = S_IDLE;
        next_sendBusy    = 1'b0;
      end else if (budget == 8'd1 && next_sendBusy) begin
        next_sendBusy = 1'b0;
        if (next_sendState == S_PUSH || next_sendState == S_WAIT) begin
          next_txValid   = 1'b0;
          next_sendState = S_READ;
        end
      end
    end else if (sendState == S_IDLE) begin
      next_txValid = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sendState   <= S_IDLE;
      count       <= `RST_WORD;
      budget      <= 8'h00;
      sendBusy    <= 1'b0;
      prevTrigger <= 1'b0;
      done        <= 1'b0;
      error       <= 1'b0;
      resultBit   <= 1'b0;
      status      <= `RST_WORD;
      faultDetail <= `RST_WORD;
      memRdEn     <= 1'b0;
      memRdAddr   <= `RST_WORD;
      txByte      <= 8'h00;
      txValid     <= 1'b0;
    end else begin
      sendState   <= next_sendState;
      count       <= next_count;
      budget      <= next_budget;
      sendBusy    <= next_sendBusy;
      prevTrigger <= next_prevTrigger;
      done        <= next_done;
      error       <= next_error;
      resultBit   <= next_resultBit;
      status      <= next_status;
      faultDetail <= next_faultDetail;
      memRdEn     <= next_memRdEn;
      memRdAddr   <= next_memRdAddr;
      txByte      <= next_txByte;
      txValid     <= next_txValid;
    end
  end

  frame_receive_job #(
    .CALL_BUDGET (CALL_BUDGET),
    .MAX_BYTES   (MAX_BYTES)
  ) receiveJob (
    .core_clk     (core_clk),
    .nrst         (nrst),
    .call         (recvCall.job),
    .rxFrameReady (rxFrameReady),
    .rxByte       (rxByte),
    .rxValid      (rxValid),
    .rxLast       (rxLast),
    .rxReady      (rxReady),
    .memWrEn      (memWrEn),
    .memWrAddr    (memWrAddr),
    .memWrData    (memWrData)
  );
endmodule : frame_transfer_jobs
`default_nettype wire

/* File: frame_transfer_jobs_assertions.sv */
// port checks of the frame transfer jobs
`timescale 1ns/100ps
`default_nettype none
module frame_transfer_jobs_assertions #(
  parameter int CALL_BUDGET = 64
) (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       txValid,
  input wire logic       txReady,
  input wire logic [7:0] txByte,
  input wire logic       rxValid,
  input wire logic       rxReady,
  input wire logic [7:0] rxByte,
  input wire logic       memWrEn,
  input wire logic [7:0] memWrData
);
  import frame_jobs_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [7:0] waitCnt, next_waitCnt;
  // access cycles still waiting for pready
  always_comb next_waitCnt = (psel && penable && !pready) ? waitCnt + 8'h01 : 8'h00;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) waitCnt <= 8'h00;
    else waitCnt <= next_waitCnt;
  end
  sequence s_stall;
    txValid && !txReady ##1 txValid;
  endsequence
  a_pready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_slverr_ready: assert property (pslverr |-> pready) else $error("lone pslverr");
  a_ready_access: assert property (pready |-> psel && penable) else $error("stray pready");
  a_call_bounded: assert property (waitCnt <= 8'(CALL_BUDGET + 2))
    else $error("call too long");
  a_tx_in_call: assert property (txValid |-> psel && penable)
    else $error("byte outside call");
  a_tx_held: assert property (s_stall |-> $stable(txByte))
    else $error("byte changed");
  a_rx_in_call: assert property (rxReady |-> psel && penable)
    else $error("rx outside call");
  a_wr_after_rx: assert property (memWrEn |-> $past(rxValid && rxReady) && memWrData == $past(rxByte))
    else $error("bad store");
endmodule : frame_transfer_jobs_assertions
bind frame_transfer_jobs frame_transfer_jobs_assertions #(.CALL_BUDGET(CALL_BUDGET)) u_chk (.core_clk, .nrst,
  .psel, .penable, .pready, .pslverr, .txValid, .txReady, .txByte, .rxValid, .rxReady, .rxByte, .memWrEn,
  .memWrData);
`default_nettype wire

/* File: frame_module_model.sv */
// memory and serial module stand-in
`timescale 1ns/100ps
`default_nettype none
module frame_module_model (
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire logic                  stall,
  input  wire frame_jobs_pkg::word_t rxEnd,
  input  wire logic                  memRdEn,
  input  wire frame_jobs_pkg::word_t memRdAddr,
  output var  frame_jobs_pkg::byte_t memRdData,
  input  wire frame_jobs_pkg::byte_t txByte,
  input  wire logic                  txValid,
  output var  logic                  txReady,
  output var  logic                  rxFrameReady,
  output var  frame_jobs_pkg::byte_t rxByte,
  output var  logic                  rxValid,
  output var  logic                  rxLast,
  input  wire logic                  rxReady
);
  import frame_jobs_pkg::*;
  int    txCount;
  byte_t txLog [0:255];
  word_t rxIdx;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      txReady <= 1'h0;
      txCount <= 0;
      rxIdx <= 16'h0000;
    end else begin
      txReady <= stall ? ~txReady : 1'h1;
      if (txValid && txReady) begin
        txLog[txCount[7:0]] <= txByte;
        txCount <= txCount + 1;
      end
      if (rxValid && rxReady) rxIdx <= rxIdx + 16'h0001;
    end
  end
  // frame runs from rxIdx up to rxEnd - 1, the byte that carries rxLast
  assign rxFrameReady = rxIdx < rxEnd;
  assign rxValid = rxFrameReady;
  assign rxLast = rxValid && (rxIdx == rxEnd - 16'h0001);
  assign rxByte = rxValid ? rxIdx[7:0] : ~rxIdx[7:0];
  // memory answers within the cycle of its read strobe
  assign memRdData = memRdEn ? (memRdAddr[7:0] ^ 8'h5a) : ~(memRdAddr[7:0] ^ 8'h5a);
endmodule : frame_module_model
`default_nettype wire

/* File: frame_transfer_jobs_bench.sv */
// self-checking bench of the frame transfer jobs
`timescale 1ns/100ps
`default_nettype none
`include "frame_jobs_consts.svh"
module frame_transfer_jobs_bench;
  import frame_jobs_pkg::*;
  logic        core_clk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        txFault = 1'h0, stall = 1'h0, hung = 1'h0, er;
  logic        pready, pslverr, memRdEn, txValid, txReady, rxFrameReady, rxValid, rxLast, rxReady;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  word_t       moduleBaseAddress, memRdBlock, memRdAddr, txFaultCode = 16'h00c3, rxEnd = 16'h0000;
  word_t       memWrBlock, memWrAddr;
  byte_t       memRdData, txByte, rxByte;
  int          n_mismatch = 0, n_checks = 0;
  always #10 core_clk = ~core_clk;
  frame_transfer_jobs #(.CALL_BUDGET(8)) dut (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .moduleBaseAddress, .memRdEn, .memRdBlock, .memRdAddr, .memRdData, .txByte,
    .txValid, .txReady, .txFault, .txFaultCode, .rxFrameReady, .rxByte, .rxValid, .rxLast, .rxReady,
    .memWrEn(), .memWrBlock, .memWrAddr, .memWrData());
  frame_module_model m (.core_clk, .nrst, .stall, .rxEnd, .memRdEn, .memRdAddr, .memRdData, .txByte,
    .txValid, .txReady, .rxFrameReady, .rxByte, .rxValid, .rxLast, .rxReady);
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'h1 && k < 200);
    rd = prdata;
    er = pslverr;
    if (k >= 200) hung = 1'h1;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
  endtask : apb
  // one program cycle, then its result word
  task automatic call(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
    apb(1'h0, a + 8'h04, 32'h0);
  endtask : call
  task automatic t_regs;
    apb(1'h0, `ADDR_SEND_RESULT, 32'h0);
    chk(rd, 32'h0);
    apb(1'h1, `ADDR_MOD_BASE, 32'h0123);
    chk(32'(moduleBaseAddress), 32'h0123);
    apb(1'h0, 8'h40, 32'h0);
    chk({rd[30:0], er}, 32'h1);
  endtask : t_regs
  task automatic t_send(input word_t off, input word_t len, input logic slow);
    int c;
    int b;
    b = m.txCount;
    stall <= slow;
    apb(1'h1, `ADDR_SEND_BLOCK, 32'h5);
    apb(1'h1, `ADDR_SEND_OFFSET, 32'(off));
    apb(1'h1, `ADDR_SEND_LEN, 32'(len));
    call(`ADDR_SEND_CALL, 32'h0);
    c = 0;
    do begin
      call(`ADDR_SEND_CALL, 32'h1);
      c++;
    end while (rd[0] !== 1'h1 && c < 100);
    chk(rd, 32'h5);
    chk(32'(memRdBlock), 32'h5);
    chk(m.txCount - b, 32'(len));
    for (int i = 0; i < len; i++) chk(32'(m.txLog[8'(b + i)]), 32'(8'(off + i) ^ 8'h5a));
    if (c >= 100) hung = 1'h1;
  endtask : t_send
  task automatic t_cancel;
    int b;
    apb(1'h1, `ADDR_SEND_LEN, 32'h28);
    call(`ADDR_SEND_CALL, 32'h0);
    call(`ADDR_SEND_CALL, 32'h1);
    call(`ADDR_SEND_CALL, 32'h2);
    chk(rd, {`ST_SEND_ABORT, 16'h0002});
    b = m.txCount;
    call(`ADDR_SEND_CALL, 32'h3);
    chk(rd, 32'h0);
    call(`ADDR_SEND_CALL, 32'h1);
    chk(rd, 32'h0);
    call(`ADDR_SEND_CALL, 32'h2);
    chk(m.txCount - b, 32'h0);
  endtask : t_cancel
  task automatic t_fault;
    call(`ADDR_SEND_CALL, 32'h0);
    txFault <= 1'h1;
    call(`ADDR_SEND_CALL, 32'h1);
    chk(rd, {`ST_MODULE_FAULT, 16'h0002});
    txFault <= 1'h0;
    apb(1'h0, `ADDR_FAULT_INFO, 32'h0);
    chk(rd, 32'(txFaultCode));
  endtask : t_fault
  task automatic t_recv(input word_t n);
    int c;
    rxEnd <= rxEnd + n;
    c = 0;
    do begin
      call(`ADDR_RECV_CALL, 32'h0);
      c++;
    end while (rd[0] !== 1'h1 && c < 100);
    chk(rd, 32'h5);
    apb(1'h0, `ADDR_RECV_LEN, 32'h0);
    chk(rd, 32'(n));
    chk(32'(memWrAddr), 32'(n) + 32'h0f);
    chk(32'(memWrBlock), 32'h7);
    if (c >= 100) hung = 1'h1;
  endtask : t_recv
  task automatic t_reset;
    nrst <= 1'h0;
    @(posedge core_clk);
    nrst <= 1'h1;
    @(posedge core_clk);
    apb(1'h0, `ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
  endtask : t_reset
  task automatic t_rabort;
    int b;
    rxEnd <= rxEnd + 16'h001e;
    call(`ADDR_RECV_CALL, 32'h0);
    apb(1'h1, `ADDR_CTRL, 32'h0);
    call(`ADDR_RECV_CALL, 32'h0);
    chk(rd, {`ST_RECV_DISABLED, 16'h0002});
    b = m.rxIdx;
    call(`ADDR_RECV_CALL, 32'h0);
    chk(32'(m.rxIdx), 32'(b));
    apb(1'h1, `ADDR_CTRL, 32'h1);
    call(`ADDR_RECV_CALL, 32'h0);
    call(`ADDR_RECV_CALL, 32'h2);
    chk(rd, {`ST_RECV_RESET, 16'h0002});
    apb(1'h0, `ADDR_RECV_LEN, 32'h0);
    chk(rd, 32'h0);
  endtask : t_rabort
  initial begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'h1;
    @(posedge core_clk);
    t_regs();
    t_send(16'h1ffe, 16'h0001, 1'h0);
    t_send(16'h0000, 16'h0014, 1'h1);
    t_cancel();
    t_fault();
    apb(1'h1, `ADDR_RECV_BLOCK, 32'h7);
    apb(1'h1, `ADDR_RECV_OFFSET, 32'h10);
    apb(1'h1, `ADDR_CTRL, 32'h1);
    t_recv(16'h0005);
    t_recv(16'h0014);
    t_rabort();
    t_reset();
    test_done();
  end
  initial begin
    wait (hung);
    n_mismatch++;
    test_done();
  end
endmodule : frame_transfer_jobs_bench
`default_nettype wire
